/* pkg/sqg_regs.svh */
`ifndef SQG_REGS_SVH
`define SQG_REGS_SVH
// Notes on behaviour
// - From slot end one to slot end two, only slot-two mask classes send.
// - From slot end two to slot end three, only slot-three mask classes send.
// - From slot end three to cycle end, only last-slot mask classes send.
// - Enabled but before first cycle time, only prestart mask classes send.
// - Read-only word shows the compare time loaded after current slot end.
// - With enable bit three, interrupt every cycle at slot end three.
// - With enable bit two, interrupt every cycle at slot end two.
// - With enable bit one, interrupt every cycle at slot end one.
// - With enable bit zero, interrupt at every cycle start.
// - Cycle-start interrupt also fires for the very first cycle.
// - Highest enabled class is granted first; none enabled means none sends.
// - Masks govern only ports picked in scheduled port select.
// - Cycle starts when time reaches first cycle time, then each period.
// - Events latch pending flags regardless of enables; writing one clears.

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SQG_ADDR_CTRL       32'h44053f00
`define SQG_ADDR_PORTS      32'h44053f04
`define SQG_ADDR_FIRST      32'h44053f08
`define SQG_ADDR_MODULO     32'h44053f0c
`define SQG_ADDR_PERIOD     32'h44053f10
`define SQG_ADDR_END_ONE    32'h44053f14
`define SQG_ADDR_END_TWO    32'h44053f18
`define SQG_ADDR_END_THREE  32'h44053f1c
`define SQG_ADDR_MASK_FIRST 32'h44053f20
`define SQG_ADDR_MASK_TWO   32'h44053f24
`define SQG_ADDR_MASK_THREE 32'h44053f28
`define SQG_ADDR_MASK_LAST  32'h44053f2c
`define SQG_ADDR_MASK_PRE   32'h44053f30
`define SQG_ADDR_LOAD_NEXT  32'h44053f34
`define SQG_ADDR_IRQ_EN     32'h44053f38
`define SQG_ADDR_IRQ_PEND   32'h44053f3c

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SQG_CTRL_EN_BIT  0
`define SQG_PORTS        5
`define SQG_WORD_RST     32'h00000000
`define SQG_MASK_RST     4'h0
`define SQG_OPEN_MASK    4'hf
`define SQG_PORTS_RST    5'h00
`define SQG_HALF_WRAP    32'h80000000

`endif

/* pkg/sqg_pkg.sv */
package sqg_pkg;
  // Scheduler phase, one-hot
  typedef enum logic [2:0] {
    SQG_IDLE = 3'b001,
    SQG_WAIT = 3'b010,
    SQG_RUN  = 3'b100
  } sqg_state_t;
  typedef logic [3:0] sqg_mask_t;
endpackage

/* pkg/sqg_sched_if.sv */
`timescale 1ns/1ns
interface sqg_sched_if;
  logic                enable;
  logic [31:0]         first_time;
  logic [31:0]         modulo;
  logic [31:0]         period;
  logic [31:0]         end_one;
  logic [31:0]         end_two;
  logic [31:0]         end_three;
  sqg_pkg::sqg_state_t state;
  logic [1:0]          slot;
  logic [3:0]          events;
  logic [31:0]         load_next;
  modport cfg (output enable, first_time, modulo, period, end_one,
               end_two, end_three,
               input  state, slot, events, load_next);
  modport eng (input  enable, first_time, modulo, period, end_one,
               end_two, end_three,
               output state, slot, events, load_next);
endinterface

/* hdl/sqg_engine.sv */
`timescale 1ns/1ns
`include "sqg_regs.svh"
module sqg_engine (
  input  wire logic        sys_clk,  // Switch clock
  input  wire logic        rst_n,    // Sync reset, active low
  input  wire logic [31:0] sys_time, // System time, same clock
  sqg_sched_if.eng         sched     // Config in, slot state out
);
  logic [31:0] base;
  logic [31:0] cmp;
  logic [31:0] nxt_base;
  logic [1:0]  nxt_slot;
  logic        hit;

  // Sum wrapped at the timer modulo, zero meaning two to the 32
  function automatic logic [31:0] add_m(input logic [31:0] a,
                                        input logic [31:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (sched.modulo != 32'h0 && s >= {1'b0, sched.modulo})
      s = s - {1'b0, sched.modulo};
    return s[31:0];
  endfunction

  // Time reached or crossed, judged on the wrapped distance
  function automatic logic reached(input logic [31:0] t,
                                   input logic [31:0] c);
    logic [31:0] d;
    logic [31:0] half;
    d = t - c;
    if (sched.modulo != 32'h0 && t < c)
      d = t + sched.modulo - c;
    half = (sched.modulo == 32'h0) ? `SQG_HALF_WRAP
                                   : {1'b0, sched.modulo[31:1]};
    return d < half;
  endfunction

  // Slot that runs to the end of the cycle
  function automatic logic is_last(input logic [1:0] s);
    return (s == 2'h3) || (s == 2'h1 && sched.end_two == 32'h0) ||
           (s == 2'h2 && sched.end_three == 32'h0);
  endfunction

  // Absolute end time of slot s in the cycle starting at b
  function automatic logic [31:0] end_of(input logic [1:0]  s,
                                         input logic [31:0] b);
    logic [31:0] off;
    off = (s == 2'h0) ? sched.end_one :
          (s == 2'h1) ? sched.end_two : sched.end_three;
    return is_last(s) ? add_m(b, sched.period) : add_m(b, off + 32'h1);
  endfunction

  // Following slot and its cycle base
  always_comb begin
    nxt_base = is_last(sched.slot) ? add_m(base, sched.period) : base;
    nxt_slot = is_last(sched.slot) ? 2'h0 : sched.slot + 2'h1;
    hit      = reached(sys_time, cmp);
  end

  // Compare value loaded after the running slot ends
  assign sched.load_next =
    (sched.state == sqg_pkg::SQG_RUN)  ? end_of(nxt_slot, nxt_base) :
    (sched.state == sqg_pkg::SQG_WAIT) ? end_of(2'h0, cmp) :
                                         sched.first_time;

  // Slot sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sched.state  <= sqg_pkg::SQG_IDLE;
      sched.slot   <= 2'h0;
      sched.events <= 4'h0;
      base         <= `SQG_WORD_RST;
      cmp          <= `SQG_WORD_RST;
    end else begin
      sched.events <= 4'h0;
      if (!sched.enable) begin
        sched.state <= sqg_pkg::SQG_IDLE;
      end else begin
        unique case (sched.state)
          sqg_pkg::SQG_IDLE: begin
            sched.state <= sqg_pkg::SQG_WAIT;
            cmp         <= sched.first_time;
          end
          sqg_pkg::SQG_WAIT: if (hit) begin
            sched.state  <= sqg_pkg::SQG_RUN;
            sched.slot   <= 2'h0;
            base         <= cmp;
            cmp          <= end_of(2'h0, cmp);
            sched.events <= 4'h1;
          end
          sqg_pkg::SQG_RUN: if (hit) begin
            sched.slot   <= nxt_slot;
            base         <= nxt_base;
            cmp          <= end_of(nxt_slot, nxt_base);
            sched.events <= 4'h1 << nxt_slot;
          end
          default: sched.state <= sqg_pkg::SQG_IDLE;
        endcase
      end
    end
  end

  property p_first_cycle;
    @(posedge sys_clk) disable iff (!rst_n)
    (sched.enable && sched.state == sqg_pkg::SQG_WAIT && hit)
      |=> (sched.state == sqg_pkg::SQG_RUN && sched.events == 4'h1);
  endproperty
  a_first_cycle: assert property (p_first_cycle)
    else $error("first cycle start not taken");
endmodule

/* hdl/sqg_top.sv */
`timescale 1ns/1ns
`include "sqg_regs.svh"
module sqg_top (
  input  wire logic        sys_clk,          // Switch clock, 125 MHz
  input  wire logic        rst_n,            // Sync reset, active low
  input  wire logic [31:0] avs_address,      // Byte address
  input  wire logic        avs_read,         // Read request
  input  wire logic        avs_write,        // Write request
  input  wire logic [31:0] avs_writedata,    // Write data
  input  wire logic [3:0]  avs_byteenable,   // Byte lanes
  output logic      [31:0] avs_readdata,     // Read data
  output logic             avs_waitrequest,  // Stall
  input  wire logic [31:0] sys_time,         // System time
  input  wire logic [3:0]  class_ready,      // Classes with frames
  output logic      [3:0]  class_allow,      // Active slot mask
  output logic      [3:0]  class_grant,      // Granted class
  output logic      [19:0] port_class_allow, // Mask per port
  output logic             irq               // Level interrupt
);
  // ----------------------------------------
  // Configuration and status storage
  // ----------------------------------------
  logic                ctrl_en;
  logic [4:0]          port_sel;
  logic [31:0]         first_time;
  logic [31:0]         modulo;
  logic [31:0]         period;
  logic [31:0]         end_one;
  logic [31:0]         end_two;
  logic [31:0]         end_three;
  sqg_pkg::sqg_mask_t  mask_first;
  sqg_pkg::sqg_mask_t  mask_two;
  sqg_pkg::sqg_mask_t  mask_three;
  sqg_pkg::sqg_mask_t  mask_last;
  sqg_pkg::sqg_mask_t  mask_pre;
  sqg_pkg::sqg_mask_t  irq_en;
  sqg_pkg::sqg_mask_t  pend;
  sqg_pkg::sqg_mask_t  pend_clr;
  sqg_pkg::sqg_mask_t  active;
  sqg_pkg::sqg_mask_t  ready_open;
  logic [31:0]         rdata;
  logic                wr_go;
  logic                rd_take;

  sqg_sched_if sched ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Merge write data into a word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // Low nibble of a merged write, upper bits dropped
  function automatic logic [3:0] nib(input logic [3:0]  old,
                                     input logic [31:0] wd,
                                     input logic [3:0]  be);
    logic [31:0] r;
    r = be_merge({28'h0, old}, wd, be);
    return r[3:0];
  endfunction

  // Highest set bit as one-hot
  function automatic logic [3:0] prio(input logic [3:0] x);
    logic [3:0] r;
    r = 4'h0;
    if (x[3])
      r = 4'h8;
    else if (x[2])
      r = 4'h4;
    else if (x[1])
      r = 4'h2;
    else if (x[0])
      r = 4'h1;
    return r;
  endfunction

  // ----------------------------------------
  // Slot engine
  // ----------------------------------------
  assign sched.enable     = ctrl_en;
  assign sched.first_time = first_time;
  assign sched.modulo     = modulo;
  assign sched.period     = period;
  assign sched.end_one    = end_one;
  assign sched.end_two    = end_two;
  assign sched.end_three  = end_three;

  sqg_engine u_engine (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .sys_time (sys_time),
    .sched    (sched.eng)
  );

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // Write taken on the edge where waitrequest is low, read on the edge where it is high
  assign wr_go   = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && avs_waitrequest;

  // One wait cycle per access
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // Read decode, unmapped reads as zero
  always_comb begin
    rdata = 32'h0;
    case (avs_address)
      `SQG_ADDR_CTRL:       rdata = {31'h0, ctrl_en};
      `SQG_ADDR_PORTS:      rdata = {27'h0, port_sel};
      `SQG_ADDR_FIRST:      rdata = first_time;
      `SQG_ADDR_MODULO:     rdata = modulo;
      `SQG_ADDR_PERIOD:     rdata = period;
      `SQG_ADDR_END_ONE:    rdata = end_one;
      `SQG_ADDR_END_TWO:    rdata = end_two;
      `SQG_ADDR_END_THREE:  rdata = end_three;
      `SQG_ADDR_MASK_FIRST: rdata = {28'h0, mask_first};
      `SQG_ADDR_MASK_TWO:   rdata = {28'h0, mask_two};
      `SQG_ADDR_MASK_THREE: rdata = {28'h0, mask_three};
      `SQG_ADDR_MASK_LAST:  rdata = {28'h0, mask_last};
      `SQG_ADDR_MASK_PRE:   rdata = {28'h0, mask_pre};
      `SQG_ADDR_LOAD_NEXT:  rdata = sched.load_next;
      `SQG_ADDR_IRQ_EN:     rdata = {28'h0, irq_en};
      `SQG_ADDR_IRQ_PEND:   rdata = {28'h0, pend};
      default:              rdata = 32'h0;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      avs_readdata <= `SQG_WORD_RST;
    else if (rd_take)
      avs_readdata <= rdata;
  end

  // Configuration writes, only the low mask bits stored
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_en    <= 1'b0;
      port_sel   <= `SQG_PORTS_RST;
      first_time <= `SQG_WORD_RST;
      modulo     <= `SQG_WORD_RST;
      period     <= `SQG_WORD_RST;
      end_one    <= `SQG_WORD_RST;
      end_two    <= `SQG_WORD_RST;
      end_three  <= `SQG_WORD_RST;
      mask_first <= `SQG_MASK_RST;
      mask_two   <= `SQG_MASK_RST;
      mask_three <= `SQG_MASK_RST;
      mask_last  <= `SQG_MASK_RST;
      mask_pre   <= `SQG_MASK_RST;
      irq_en     <= `SQG_MASK_RST;
    end else if (wr_go) begin
      case (avs_address)
        `SQG_ADDR_CTRL:
          if (avs_byteenable[0])
            ctrl_en <= avs_writedata[`SQG_CTRL_EN_BIT];
        `SQG_ADDR_PORTS:
          if (avs_byteenable[0])
            port_sel <= avs_writedata[4:0];
        `SQG_ADDR_FIRST:
          first_time <= be_merge(first_time, avs_writedata,
                                 avs_byteenable);
        `SQG_ADDR_MODULO:
          modulo <= be_merge(modulo, avs_writedata, avs_byteenable);
        `SQG_ADDR_PERIOD:
          period <= be_merge(period, avs_writedata, avs_byteenable);
        `SQG_ADDR_END_ONE:
          end_one <= be_merge(end_one, avs_writedata, avs_byteenable);
        `SQG_ADDR_END_TWO:
          end_two <= be_merge(end_two, avs_writedata, avs_byteenable);
        `SQG_ADDR_END_THREE:
          end_three <= be_merge(end_three, avs_writedata,
                                avs_byteenable);
        `SQG_ADDR_MASK_FIRST:
          mask_first <= nib(mask_first, avs_writedata, avs_byteenable);
        `SQG_ADDR_MASK_TWO:
          mask_two <= nib(mask_two, avs_writedata, avs_byteenable);
        `SQG_ADDR_MASK_THREE:
          mask_three <= nib(mask_three, avs_writedata, avs_byteenable);
        `SQG_ADDR_MASK_LAST:
          mask_last <= nib(mask_last, avs_writedata, avs_byteenable);
        `SQG_ADDR_MASK_PRE:
          mask_pre <= nib(mask_pre, avs_writedata, avs_byteenable);
        `SQG_ADDR_IRQ_EN:
          irq_en <= nib(irq_en, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Write one to clear pending bits
  always_comb begin
    pend_clr = 4'h0;
    if (wr_go && avs_address == `SQG_ADDR_IRQ_PEND &&
        avs_byteenable[0])
      pend_clr = avs_writedata[3:0];
  end

  // Events latch regardless of enables, set beats clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      pend <= `SQG_MASK_RST;
    else
      pend <= (pend & ~pend_clr) | sched.events;
  end

  // Level interrupt from enabled pending bits
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(pend & irq_en);
  end

  // ----------------------------------------
  // Queue gating
  // ----------------------------------------
  // Mask of the running slot
  always_comb begin
    active = `SQG_OPEN_MASK;
    unique case (sched.state)
      sqg_pkg::SQG_IDLE: active = `SQG_OPEN_MASK;
      sqg_pkg::SQG_WAIT: active = mask_pre;
      sqg_pkg::SQG_RUN: begin
        unique case (sched.slot)
          2'h0: active = mask_first;
          2'h1: active = mask_two;
          2'h2: active = mask_three;
          2'h3: active = mask_last;
        endcase
      end
      default: active = 4'h0;
    endcase
  end

  // Ready classes open in the running slot
  assign ready_open = class_ready & active;

  // Slot mask and priority grant
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      class_allow <= `SQG_OPEN_MASK;
      class_grant <= 4'h0;
    end else begin
      class_allow <= active;
      class_grant <= prio(ready_open);
    end
  end

  // Masks apply only to scheduled ports
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_class_allow <= {`SQG_PORTS{`SQG_OPEN_MASK}};
    end else begin
      for (int p = 0; p < `SQG_PORTS; p++) begin
        port_class_allow[p*4 +: 4] <=
          port_sel[p] ? active : `SQG_OPEN_MASK;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_in_slot(logic [1:0] n);
    sched.state == sqg_pkg::SQG_RUN && sched.slot == n;
  endsequence

  sequence s_rd_next;
    rd_take && avs_address == `SQG_ADDR_LOAD_NEXT;
  endsequence

  sequence s_clear0;
    wr_go && avs_address == `SQG_ADDR_IRQ_PEND &&
    avs_byteenable[0] && avs_writedata[0] && !sched.events[0];
  endsequence

  property p_slot_two;
    s_in_slot(2'h1) |=> class_allow == $past(mask_two);
  endproperty
  a_slot_two: assert property (p_slot_two)
    else $error("slot two mask not applied");

  property p_slot_three;
    s_in_slot(2'h2) |=> class_allow == $past(mask_three);
  endproperty
  a_slot_three: assert property (p_slot_three)
    else $error("slot three mask not applied");

  property p_last_slot;
    s_in_slot(2'h3) |=> class_allow == $past(mask_last);
  endproperty
  a_last_slot: assert property (p_last_slot)
    else $error("last slot mask not applied");

  property p_prestart;
    sched.state == sqg_pkg::SQG_WAIT
      |=> class_allow == $past(mask_pre);
  endproperty
  a_prestart: assert property (p_prestart)
    else $error("prestart mask not applied");

  property p_load_next;
    s_rd_next |=> !avs_waitrequest &&
                  avs_readdata == $past(sched.load_next);
  endproperty
  a_load_next: assert property (p_load_next)
    else $error("next compare time read wrong");

  property p_latch;
    (|sched.events) |=>
      (pend & $past(sched.events)) == $past(sched.events);
  endproperty
  a_latch: assert property (p_latch)
    else $error("event not latched");

  property p_clear;
    s_clear0 |=> !pend[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("pending bit not cleared");

  property p_irq_event;
    (|(sched.events & irq_en)) ##1 (|(pend & irq_en)) |=> irq;
  endproperty
  a_irq_event: assert property (p_irq_event)
    else $error("enabled event gave no interrupt");

  property p_irq_quiet;
    (pend & irq_en) == 4'h0 |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt without enabled pending bit");

  property p_grant;
    1'b1 |=> $onehot0(class_grant) &&
             (class_grant & ~$past(ready_open)) == 4'h0 &&
             (class_grant == 4'h0 ? $past(ready_open) == 4'h0
                                  : {1'b0, $past(ready_open)} <
                                    {class_grant, 1'b0});
  endproperty
  a_grant: assert property (p_grant)
    else $error("grant is not highest enabled class");

  property p_unsched_port;
    !port_sel[0] |=> port_class_allow[3:0] == `SQG_OPEN_MASK;
  endproperty
  a_unsched_port: assert property (p_unsched_port)
    else $error("unscheduled port was gated");
endmodule

/* testbench/sqg_partner.sv */
`timescale 1ns/1ns
// ----
// System timer and queue fill model
// ----
module sqg_partner #(
  parameter int unsigned MODULO = 1000
) (
  input  wire logic        sys_clk,    // Switch clock
  input  wire logic        rst_n,      // Sync reset, active low
  output logic      [31:0] sys_time,   // Wrapped time
  output int unsigned      ticks,      // Unwrapped time
  output logic      [3:0]  class_ready // Classes with frames
);
  int unsigned cnt = 0;
  logic [3:0]  rdy = 4'h0;
  // Time steps each clock; fill changes every eight ticks
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= 0;
      rdy <= 4'h0;
    end else begin
      cnt <= cnt + 1;
      if (cnt % 8 == 7) rdy <= 4'($urandom);
    end
  end
  assign ticks       = cnt;
  assign sys_time    = 32'(cnt % MODULO);
  assign class_ready = rdy;
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`include "sqg_regs.svh"
module tb_top;
  localparam int FT = 300, PER = 160, E1 = 39, E2 = 79, E3 = 119;
  logic        sys_clk, rst_n, avs_read, avs_write, irq, wq, nr;
  logic [31:0] avs_address, avs_writedata, avs_readdata, sys_time, q;
  logic [3:0]  class_ready, class_allow, class_grant, em;
  logic [19:0] port_class_allow;
  logic [4:0]  ports;
  logic [3:0]  msk [5];
  int unsigned ticks;
  int          num_errors = 0, checks = 0, cyc = 0, n, ph;
  bit          mon_on = 0;
  int          off [4] = '{0, E1 + 1, E2 + 1, E3 + 1};
  logic [31:0] rst_list [7] = '{`SQG_ADDR_MASK_FIRST, `SQG_ADDR_MASK_TWO,
    `SQG_ADDR_MASK_THREE, `SQG_ADDR_MASK_LAST, `SQG_ADDR_MASK_PRE,
    `SQG_ADDR_IRQ_PEND, 32'h44053f40};

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  sqg_top dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(wq), .sys_time(sys_time),
    .class_ready(class_ready), .class_allow(class_allow),
    .class_grant(class_grant), .port_class_allow(port_class_allow),
    .irq(irq));

  sqg_partner #(.MODULO(1000)) timer (.sys_clk(sys_clk), .rst_n(rst_n),
    .sys_time(sys_time), .ticks(ticks), .class_ready(class_ready));

  // ----
  // Compare, bus and model helpers
  // ----
  task automatic chk(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input bit w, input logic [31:0] a, d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (n >= 50) chk(0, 1, "bus stall");
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp, "read");
  endtask

  task automatic wait_t(input int unsigned t);
    while (ticks < t) @(posedge sys_clk);
  endtask

  function automatic logic [3:0] top1(input logic [3:0] v);
    for (int i = 3; i >= 0; i--) if (v[i]) return 4'(1 << i);
    return 4'h0;
  endfunction

  function automatic logic [3:0] exp_mask(input int t, output logic near);
    int p;
    if (t < FT) begin
      near = 1'b0;
      return msk[4];
    end
    p = (t - FT) % PER;
    near = p < 4 || (p > E1 && p < E1 + 5) || (p > E2 && p < E2 + 5)
      || (p > E3 && p < E3 + 5);
    return p <= E1 ? msk[0] : p <= E2 ? msk[1] : p <= E3 ? msk[2] : msk[3];
  endfunction

  task test_done;
    $display("num_errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----
  // Slot mask monitor and hang guard
  // ----
  always @(posedge sys_clk) begin
    if (mon_on) begin
      em = exp_mask(int'(ticks), nr);
      if (!nr) begin
        chk(class_allow, em, "allow");
        for (int p = 0; p < 5; p++)
          chk(port_class_allow[4*p+:4], ports[p] ? em : 4'hf, "port");
        if (ticks % 8 inside {[3:6]})
          chk(class_grant, top1(class_ready & em), "grant");
      end
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      test_done();
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 32'h0;
    avs_writedata = 32'h0;
    void'($urandom(32'he55b));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk(class_allow, 4'hf, "idle");
    foreach (rst_list[i]) rdc(rst_list[i], 32'h0);
    ports = 5'(($urandom | 1) & ~2);
    wr(`SQG_ADDR_PORTS, {27'h0, ports});
    wr(`SQG_ADDR_FIRST, FT);
    wr(`SQG_ADDR_MODULO, 32'h3e8);
    wr(`SQG_ADDR_PERIOD, PER);
    wr(`SQG_ADDR_END_ONE, E1);
    wr(`SQG_ADDR_END_TWO, E2);
    wr(`SQG_ADDR_END_THREE, E3);
    for (int i = 0; i < 5; i++) begin
      msk[i] = 4'($urandom);
      wr(`SQG_ADDR_MASK_FIRST + 32'(4 * i), {28'h0, msk[i]});
    end
    for (int i = 0; i < 5; i++)
      rdc(`SQG_ADDR_MASK_FIRST + 32'(4 * i), {28'h0, msk[i]});
    wr(`SQG_ADDR_IRQ_EN, 32'h1);
    rdc(`SQG_ADDR_IRQ_EN, 32'h1);
    wr(`SQG_ADDR_CTRL, 32'h1);
    repeat (3) @(posedge sys_clk);
    mon_on = 1'b1;
    rdc(`SQG_ADDR_LOAD_NEXT, FT + E1 + 1);
    wait_t(FT - 3);
    chk(irq, 1'b0, "early irq");
    wait_t(FT + 6);
    chk(irq, 1'b1, "first cycle irq");
    rdc(`SQG_ADDR_IRQ_PEND, 32'h1);
    rdc(`SQG_ADDR_LOAD_NEXT, FT + E2 + 1);
    wr(`SQG_ADDR_IRQ_EN, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0, "masked irq");
    wait_t(FT + PER + 5);
    rdc(`SQG_ADDR_IRQ_PEND, 32'hf);
    wr(`SQG_ADDR_IRQ_PEND, 32'hf);
    rdc(`SQG_ADDR_IRQ_PEND, 32'h0);
    for (int b = 0; b < 4; b++) begin
      wr(`SQG_ADDR_IRQ_PEND, 32'hf);
      wr(`SQG_ADDR_IRQ_EN, 32'(1 << b));
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(posedge sys_clk);
        n++;
      end
      ph = (int'(ticks) - FT - off[b]) % PER;
      chk(ph >= 0 && ph < 10, 1, "event time");
      wr(`SQG_ADDR_IRQ_PEND, 32'(1 << b));
      repeat (3) @(posedge sys_clk);
      chk(irq, 1'b0, "cleared irq");
      wr(`SQG_ADDR_IRQ_EN, 32'h0);
    end
    wait_t(1400);
    mon_on = 1'b0;
    wr(`SQG_ADDR_CTRL, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(class_allow, 4'hf, "disabled allow");
    chk(port_class_allow, 20'hfffff, "disabled ports");
    test_done();
  end
endmodule
